// ==== core/ccc_cfg.svh ====
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH
// Register byte offsets
`define CCC_CTRL_OFS 12'h000
`define CCC_STS_OFS 12'h004
// Control field positions
`define CCC_RUN_BIT 0
`define CCC_STYLE_BIT 1
`define CCC_CROP_BIT 2
`define CCC_COMP_BIT 3
`define CCC_SYNC_BIT 4
`define CCC_EDGE_BIT 5
`define CCC_LPOL_BIT 6
`define CCC_FPOL_BIT 7
`define CCC_RATE_LO 8
`define CCC_RATE_HI 9
`define CCC_WID_LO 10
`define CCC_WID_HI 11
`define CCC_EN_BIT 14
`define CCC_CTRL_MASK 32'h0000_4fff
`define CCC_CTRL_RST 32'h0000_0000
// Status field positions
`define CCC_LST_BIT 0
`define CCC_FST_BIT 1
`define CCC_NEMP_BIT 2
`define CCC_STS_RST 32'h0000_0000
// Embedded code bytes and defaults
`define CCC_CODE_FF 8'hff
`define CCC_CODE_00 8'h00
`define CCC_FS_CODE 8'h80
`define CCC_FE_CODE 8'h9d
`define CCC_LS_CODE 8'hab
`define CCC_LE_CODE 8'hb6
`define CCC_FIFO_DEPTH 4
`endif

// ==== core/ccc_pkg.sv ====
package ccc_pkg;
   typedef enum logic [1:0] {
      CCC_IDLE,
      CCC_WAIT,
      CCC_GRAB
   } ccc_state_t;
   typedef enum logic [1:0] {
      CCC_W8,
      CCC_W10,
      CCC_W12,
      CCC_W14
   } ccc_width_t;
endpackage

// ==== core/ccc_pin_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pins
module ccc_pin_sync #(
   parameter int WIDTH = 17
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         pin_sync <= '0;
      end else if (clk_en) begin
         stage1 <= pin_in;
         pin_sync <= stage1;
      end
   end
endmodule

// ==== core/ccc_word_fifo.sv ====
`timescale 1ns/1ps
`include "ccc_cfg.svh"
// Small word FIFO; overwrites nothing, drops when full
module ccc_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = `CCC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic flush,
   // Write side
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   // Read side
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign wr_ready = (count != AW'(0) + (AW+1)'(DEPTH));
   assign rd_valid = (count != '0);
   assign rd_data = mem[rptr];
   assign push = wr_valid && wr_ready;
   assign pop = rd_valid && rd_ready;

   always_ff @(posedge pclk) begin
      if (clk_en && push) begin
         mem[wptr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else if (clk_en) begin
         if (flush) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
         end else begin
            if (push) begin
               wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
            end
            if (pop) begin
               rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
         end
      end
   end
endmodule

// ==== core/ccc_capture.sv ====
`timescale 1ns/1ps
`include "ccc_cfg.svh"
//==============================================================
module ccc_capture
   import ccc_pkg::*;
#(
   parameter int FIFO_DEPTH = `CCC_FIFO_DEPTH,
   parameter logic [31:0] CROP_START = 32'h0000_0000,
   parameter logic [31:0] CROP_SIZE = 32'hffff_ffff
) (
   // Clock, enable and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Camera pins
   input wire logic pixel_clock_in,
   input wire logic line_sync_in,
   input wire logic frame_sync_in,
   input wire logic [13:0] pixel_data_in,
   // Captured word stream
   output logic word_valid,
   output logic [31:0] word_data,
   input wire logic word_ready
);
   //==============================================================
   // Control register and APB
   logic [31:0] capture_control;
   logic [31:0] capture_status;
   logic capture_run;
   logic capture_style;
   logic crop_select;
   logic compressed_format;
   logic sync_source_select;
   logic sample_edge_select;
   logic line_sync_polarity;
   logic frame_sync_polarity;
   logic [1:0] frame_rate_field;
   ccc_width_t pixel_width_field;
   logic module_enable;
   logic apb_wr;
   logic run_clear;

   assign capture_run = capture_control[`CCC_RUN_BIT];
   assign capture_style = capture_control[`CCC_STYLE_BIT];
   assign crop_select = capture_control[`CCC_CROP_BIT];
   assign compressed_format = capture_control[`CCC_COMP_BIT];
   assign sync_source_select = capture_control[`CCC_SYNC_BIT];
   assign sample_edge_select = capture_control[`CCC_EDGE_BIT];
   assign line_sync_polarity = capture_control[`CCC_LPOL_BIT];
   assign frame_sync_polarity = capture_control[`CCC_FPOL_BIT];
   assign frame_rate_field = capture_control[`CCC_RATE_HI:`CCC_RATE_LO];
   assign pixel_width_field = ccc_width_t'(capture_control[`CCC_WID_HI:`CCC_WID_LO]);
   assign module_enable = capture_control[`CCC_EN_BIT];

   // Zero-wait slave; unmapped addresses read zero with an error
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite && clk_en;

   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == `CCC_CTRL_OFS) begin
         prdata = capture_control;
      end else if (paddr == `CCC_STS_OFS) begin
         prdata = capture_status;
         pslverr = psel && penable && pwrite;
      end else begin
         pslverr = psel && penable;
      end
   end

   // Hardware clear of the run bit beats a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_control <= `CCC_CTRL_RST;
      end else if (clk_en) begin
         if (apb_wr && paddr == `CCC_CTRL_OFS) begin
            capture_control <= pwdata & `CCC_CTRL_MASK;
         end
         if (run_clear) begin
            capture_control[`CCC_RUN_BIT] <= 1'b0;
         end
      end
   end

   //==============================================================
   // Pin synchronisers and pixel clock edge detect
   logic [16:0] pins_sync;
   logic pclk_s;
   logic pclk_d;
   logic lsync_s;
   logic fsync_s;
   logic [13:0] pdata_s;
   logic sample;
   logic line_valid;
   logic frame_valid;

   ccc_pin_sync #(
      .WIDTH(17)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pin_in({pixel_clock_in, line_sync_in, frame_sync_in, pixel_data_in}),
      .pin_sync(pins_sync)
   );

   assign {pclk_s, lsync_s, fsync_s, pdata_s} = pins_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pclk_d <= 1'b0;
      end else if (clk_en) begin
         pclk_d <= pclk_s;
      end
   end

   // Sampling only while the interface is enabled
   assign sample = module_enable && (sample_edge_select ? (pclk_s && !pclk_d)
                                                        : (!pclk_s && pclk_d));
   assign line_valid = (lsync_s == line_sync_polarity);
   assign frame_valid = (fsync_s == frame_sync_polarity);

   //==============================================================
   // Embedded code detector
   logic [23:0] code_hist;
   logic code_hit;
   logic [7:0] code_byte;
   logic code_part;
   logic emb_fs;
   logic emb_fe;
   logic emb_ls;
   logic emb_le;
   logic emb_in_line;
   logic emb_in_frame;

   // Three fixed bytes precede the code byte
   assign code_hit = code_hist == {`CCC_CODE_FF, `CCC_CODE_00, `CCC_CODE_00};
   assign code_part = code_byte == `CCC_CODE_FF || {code_hist[7:0], code_byte} == 16'hff00 ||
                      {code_hist[15:0], code_byte} == 24'hff_0000;
   assign code_byte = pdata_s[7:0];
   assign emb_fs = sample && code_hit && code_byte == `CCC_FS_CODE;
   assign emb_fe = sample && code_hit && code_byte == `CCC_FE_CODE;
   assign emb_ls = sample && code_hit && code_byte == `CCC_LS_CODE;
   assign emb_le = sample && code_hit && code_byte == `CCC_LE_CODE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_hist <= 24'h00_0000;
         emb_in_line <= 1'b0;
         emb_in_frame <= 1'b0;
      end else if (clk_en && sample && sync_source_select) begin
         code_hist <= code_hit ? 24'h00_0000 : {code_hist[15:0], code_byte};
         if (emb_fs) begin
            emb_in_frame <= 1'b1;
         end else if (emb_fe) begin
            emb_in_frame <= 1'b0;
            emb_in_line <= 1'b0;
         end
         if (emb_ls) begin
            emb_in_line <= 1'b1;
         end else if (emb_le) begin
            emb_in_line <= 1'b0;
         end
      end
   end

   //==============================================================
   // Frame tracking and capture sequencing
   logic in_frame;
   logic in_line;
   logic frame_valid_d;
   logic frame_start;
   logic frame_end;
   logic data_beat;
   logic [1:0] skip_cnt;
   logic take_frame;
   ccc_state_t state;

   // Pixel data in embedded mode excludes the code bytes themselves
   assign in_frame = sync_source_select ? emb_in_frame : frame_valid;
   assign in_line = sync_source_select ? (emb_in_line && !code_hit && !code_part) : line_valid;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_valid_d <= 1'b0;
      end else if (clk_en && sample) begin
         frame_valid_d <= in_frame;
      end
   end

   assign frame_start = sample && in_frame && !frame_valid_d;
   assign frame_end = sample && !in_frame && frame_valid_d;

   // Rate divider: 00 all, 01 every second, 10 every third frame
   assign take_frame = capture_style || (skip_cnt == 2'd0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_cnt <= 2'd0;
      end else if (clk_en && frame_start && state == CCC_WAIT) begin
         if (skip_cnt >= frame_rate_field || frame_rate_field == 2'b11) begin
            skip_cnt <= 2'd0;
         end else begin
            skip_cnt <= skip_cnt + 2'd1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= CCC_IDLE;
      end else if (clk_en) begin
         if (!module_enable) begin
            state <= CCC_IDLE;
         end else begin
            case (state)
               CCC_IDLE: begin
                  if (capture_run) begin
                     state <= CCC_WAIT;
                  end
               end
               CCC_WAIT: begin
                  if (!capture_run) begin
                     state <= CCC_IDLE;
                  end else if (frame_start && take_frame) begin
                     state <= CCC_GRAB;
                  end
               end
               CCC_GRAB: begin
                  if (frame_end) begin
                     // Stop only at frame end
                     state <= (capture_style || !capture_run) ? CCC_IDLE : CCC_WAIT;
                  end
               end
               default: state <= CCC_IDLE;
            endcase
         end
      end
   end

   assign run_clear = (state == CCC_GRAB) && frame_end && capture_style;

   //==============================================================
   // Crop window and pixel packing
   logic [15:0] col_cnt;
   logic [15:0] row_cnt;
   logic in_window;
   logic [13:0] pix;
   logic [31:0] pack;
   logic [1:0] pack_cnt;
   logic pack_full;
   logic fifo_ready;
   logic fifo_push;
   logic [31:0] fifo_word;

   function automatic logic [13:0] width_mask(input ccc_width_t w, input logic [13:0] d);
      case (w)
         CCC_W8: width_mask = {6'd0, d[7:0]};
         CCC_W10: width_mask = {4'd0, d[9:0]};
         CCC_W12: width_mask = {2'd0, d[11:0]};
         default: width_mask = d;
      endcase
   endfunction

   assign pix = width_mask(pixel_width_field, pdata_s);
   // Window check; a window past the image edge simply never clips
   assign in_window = !crop_select || compressed_format ||
                      (col_cnt >= CROP_START[15:0] && col_cnt < CROP_START[15:0] + CROP_SIZE[15:0] &&
                       row_cnt >= CROP_START[31:16] &&
                       row_cnt < CROP_START[31:16] + CROP_SIZE[31:16]);
   // Compressed data: line sync acts as plain data enable
   assign data_beat = sample && state == CCC_GRAB && in_frame && in_line && in_window;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col_cnt <= 16'h0000;
         row_cnt <= 16'h0000;
      end else if (clk_en && sample) begin
         if (!in_frame) begin
            col_cnt <= 16'h0000;
            row_cnt <= 16'h0000;
         end else if (in_line) begin
            col_cnt <= col_cnt + 16'h0001;
         end else if (col_cnt != 16'h0000) begin
            col_cnt <= 16'h0000;
            row_cnt <= row_cnt + 16'h0001;
         end
      end
   end

   // 8-bit data packs four to a word; wider data packs two halves
   assign pack_full = (pixel_width_field == CCC_W8) ? (pack_cnt == 2'd3) : (pack_cnt == 2'd1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pack <= 32'h0000_0000;
         pack_cnt <= 2'd0;
         fifo_push <= 1'b0;
         fifo_word <= 32'h0000_0000;
      end else if (clk_en) begin
         fifo_push <= 1'b0;
         if (data_beat) begin
            if (pixel_width_field == CCC_W8) begin
               pack[pack_cnt*8 +: 8] <= pix[7:0];
            end else begin
               pack[pack_cnt[0]*16 +: 16] <= {2'b00, pix};
            end
            if (pack_full) begin
               fifo_word <= (pixel_width_field == CCC_W8) ? {pix[7:0], pack[23:0]}
                                                         : {2'b00, pix, pack[15:0]};
               fifo_push <= 1'b1;
               pack_cnt <= 2'd0;
               pack <= 32'h0000_0000;
            end else begin
               pack_cnt <= pack_cnt + 2'd1;
            end
         end else if (frame_end && state == CCC_GRAB && compressed_format && pack_cnt != 2'd0) begin
            // Compressed tail is zero-stuffed to a full word
            fifo_word <= pack;
            fifo_push <= 1'b1;
            pack_cnt <= 2'd0;
            pack <= 32'h0000_0000;
         end else if (frame_end) begin
            pack_cnt <= 2'd0;
            pack <= 32'h0000_0000;
         end
      end
   end

   ccc_word_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .flush(!module_enable),
      .wr_valid(fifo_push && module_enable),
      .wr_data(fifo_word),
      .wr_ready(fifo_ready),
      .rd_valid(word_valid),
      .rd_data(word_data),
      .rd_ready(word_ready)
   );

   //==============================================================
   // Status register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_status <= `CCC_STS_RST;
      end else if (clk_en && module_enable) begin
         capture_status[`CCC_LST_BIT] <= sync_source_select && !emb_in_line;
         capture_status[`CCC_FST_BIT] <= sync_source_select && !emb_in_frame;
         capture_status[`CCC_NEMP_BIT] <= word_valid;
      end
   end
endmodule

// ==== testbench/ccc_capture_chk.sv ====
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_capture_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Camera pins
   input wire logic pixel_clock_in,
   input wire logic line_sync_in,
   input wire logic frame_sync_in,
   input wire logic [13:0] pixel_data_in,
   // Word stream
   input wire logic word_valid,
   input wire logic [31:0] word_data,
   input wire logic word_ready
);
   //==========================
   // Shadow of control writes
   logic [31:0] shadow;
   logic [1:0] age;
   logic [2:0] off_cnt;
   wire acc = psel && penable;
   wire wr_ctrl = acc && pwrite && clk_en && paddr == `CCC_CTRL_OFS;
   wire rd_ctrl = acc && !pwrite && paddr == `CCC_CTRL_OFS;
   wire rd_sts = acc && !pwrite && paddr == `CCC_STS_OFS;
   wire en = shadow[`CCC_EN_BIT];
   // Run bit is not trusted here: snapshot clears it behind our back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) shadow <= `CCC_CTRL_RST;
      else if (wr_ctrl) shadow <= pwdata & `CCC_CTRL_MASK;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age <= 2'd0;
      else if (wr_ctrl) age <= 2'd0;
      else if (age != 2'd3) age <= age + 2'd1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) off_cnt <= 3'd0;
      else if (en) off_cnt <= 3'd0;
      else if (off_cnt != 3'd7) off_cnt <= off_cnt + 3'd1;
   end
   //==========================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_sts_write_err: assert property (acc && pwrite && paddr == `CCC_STS_OFS |-> pslverr)
      else $error("status write not refused");
   a_sts_reserved: assert property (rd_sts |-> prdata[31:3] == 29'h0 && !pslverr)
      else $error("status reserved bits set");
   a_ctrl_reserved: assert property (rd_ctrl |-> prdata[31:15] == 17'h0 && prdata[13:12] == 2'b00)
      else $error("control reserved bits set");
   a_ctrl_readback: assert property (rd_ctrl && age == 2'd3 |-> prdata[14:1] == shadow[14:1])
      else $error("control readback wrong");
   a_fifo_flag: assert property (rd_sts && en && age == 2'd3 && $stable(word_valid)
      |-> prdata[`CCC_NEMP_BIT] == word_valid)
      else $error("fifo flag disagrees with stream");
   a_pin_status: assert property (rd_sts && en && age == 2'd3 && !shadow[`CCC_SYNC_BIT]
      |-> prdata[1:0] == 2'b00)
      else $error("sync state set in pin mode");
   a_off_flush: assert property ($fell(en) |-> ##[1:4] !word_valid)
      else $error("disable did not flush");
   a_off_quiet: assert property (off_cnt >= 3'd4 |-> !word_valid)
      else $error("word while disabled");
   a_word_hold: assert property (word_valid && !word_ready && !wr_ctrl
      |=> word_valid && $stable(word_data))
      else $error("word lost while stalled");
   c_status_busy: cover property (rd_sts && prdata[`CCC_NEMP_BIT]);
   c_word: cover property ($rose(word_valid));
   c_snap_clear: cover property (rd_ctrl && shadow[`CCC_RUN_BIT] && !prdata[`CCC_RUN_BIT]);
endmodule

bind ccc_capture ccc_capture_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .pixel_clock_in, .line_sync_in,
   .frame_sync_in, .pixel_data_in, .word_valid, .word_data, .word_ready);

// ==== testbench/ccc_cam.sv ====
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_cam (
   // Link pins
   output logic pixel_clock_in,
   output logic line_sync_in,
   output logic frame_sync_in,
   output logic [13:0] pixel_data_in,
   // Setup
   input wire logic samp_rise,
   input wire logic lpol,
   input wire logic fpol
);
   logic [13:0] last = 14'h0055;
   initial begin
      pixel_clock_in = 1'b0;
      line_sync_in = 1'b1;
      frame_sync_in = 1'b1;
      pixel_data_in = 14'h0055;
   end
   //==========================
   // Inverted data round the wrong edge exposes a misplaced sample
   task automatic tick(input logic [13:0] v);
      pixel_data_in = v;
      last = v;
      #31.25 pixel_clock_in = samp_rise;
      #31.25 pixel_data_in = ~v;
      #31.25 pixel_clock_in = ~samp_rise;
      #31.25;
   endtask
   task automatic blank(input int n);
      repeat (n) tick(~last);
   endtask
   task automatic code(input logic [7:0] c);
      tick({6'h00, `CCC_CODE_FF});
      tick({6'h00, `CCC_CODE_00});
      tick({6'h00, `CCC_CODE_00});
      tick({6'h00, c});
   endtask
   task automatic park();
      pixel_clock_in = ~samp_rise;
      line_sync_in = ~lpol;
      frame_sync_in = ~fpol;
   endtask
   // Clock runs from two blank ticks before the frame to two blank ticks after it
   task automatic frame(input int lines, input int npix, input bit emb, input logic [13:0] b);
      park();
      blank(2);
      if (emb) code(`CCC_FS_CODE);
      else frame_sync_in = fpol;
      blank(2);
      for (int i = 0; i < lines; i++) begin
         if (emb) code(`CCC_LS_CODE);
         else line_sync_in = lpol;
         for (int j = 0; j < npix; j++) tick(b + 14'(i * npix + j));
         if (emb) code(`CCC_LE_CODE);
         else line_sync_in = ~lpol;
         blank(2);
      end
      if (emb) code(`CCC_FE_CODE);
      else frame_sync_in = ~fpol;
      blank(2);
   endtask
endmodule

// ==== testbench/test_camera_capture_control.sv ====
`timescale 1ns/1ps
`include "ccc_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module test_camera_capture_control;
   typedef struct {logic [31:0] ctrl; int lines; int npix; logic [13:0] base;} ccc_row_t;
   ccc_row_t rows [8] = '{
      '{32'h0000_4001, 2, 8, 14'h0110},
      '{32'h0000_44e1, 2, 8, 14'h1ff0},
      '{32'h0000_4801, 2, 8, 14'h2ff0},
      '{32'h0000_4c01, 2, 8, 14'h3ff0},
      '{32'h0000_4005, 2, 8, 14'h0020},
      '{32'h0000_4009, 1, 6, 14'h0030},
      '{32'h0000_4001, 1, 6, 14'h0030},
      '{32'h0000_4011, 2, 8, 14'h0040}};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, word_ready = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, word_data, rdat, cur, w;
   logic pready, pslverr, word_valid, rerr, pix_clk, lsync, fsync;
   logic samp_rise = 1'b0, lpol = 1'b0, fpol = 1'b0;
   logic [13:0] pix;
   logic [31:0] exp_q [$];
   int errors = 0;
   int n_compared = 0;
   initial begin
      forever #4 pclk = ~pclk;
   end
   ccc_capture DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pixel_clock_in(pix_clk), .line_sync_in(lsync),
      .frame_sync_in(fsync), .pixel_data_in(pix), .word_valid(word_valid),
      .word_data(word_data), .word_ready(word_ready));
   ccc_cam cam (.pixel_clock_in(pix_clk), .line_sync_in(lsync), .frame_sync_in(fsync),
      .pixel_data_in(pix), .samp_rise(samp_rise), .lpol(lpol), .fpol(fpol));
   //==========================
   // Stream sink, looked at where the word is settled
   always @(negedge pclk) begin
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("[ERR] %0t unexpected word %h", $time, word_data);
         end else begin
            w = exp_q.pop_front();
            `CHK(word_data, w)
         end
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 64);
      if (pready !== 1'b1) begin
         errors++;
         $display("[ERR] %0t bus answer timed out", $time);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic add_exp(input int n, input logic [13:0] b, input logic [1:0] wid, input bit cmp);
      logic [31:0] x;
      logic [13:0] s;
      int per;
      per = (wid == 2'b00) ? 4 : 2;
      x = 32'h0000_0000;
      for (int k = 0; k < n; k++) begin
         s = (b + 14'(k)) & ~(14'h3fff << (8 + 2 * int'(wid)));
         if (per == 4) x[8 * (k % 4) +: 8] = s[7:0];
         else x[16 * (k % 2) +: 16] = {2'b00, s};
         if (k % per == per - 1) begin
            exp_q.push_back(x);
            x = 32'h0000_0000;
         end
      end
      if (cmp && n % per != 0) exp_q.push_back(x);
   endtask
   task automatic setc(input logic [31:0] c);
      cur = c;
      samp_rise = c[`CCC_EDGE_BIT];
      lpol = c[`CCC_LPOL_BIT];
      fpol = c[`CCC_FPOL_BIT];
      #1 cam.park();
      apb(1'b1, `CCC_CTRL_OFS, c);
   endtask
   task automatic shot(input int l, input int n, input logic [13:0] b, input bit cap);
      if (cap) add_exp(l * n, b, cur[`CCC_WID_HI:`CCC_WID_LO], cur[`CCC_COMP_BIT]);
      cam.frame(l, n, cur[`CCC_SYNC_BIT], b);
      repeat (40) @(posedge pclk);
   endtask
   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #600_000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end
   //==========================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CCC_STS_OFS, 32'h0000_0000);
      `CHK(rdat, `CCC_STS_RST)
      apb(1'b1, `CCC_STS_OFS, 32'hffff_ffff);
      `CHK(rerr, 1'b1)
      apb(1'b0, `CCC_STS_OFS, 32'h0000_0000);
      `CHK(rdat, `CCC_STS_RST)
      apb(1'b0, 12'h008, 32'h0000_0000);
      `CHK(rerr, 1'b1)
      $display("reset test done");
      foreach (rows[i]) begin
         setc(rows[i].ctrl);
         shot(rows[i].lines, rows[i].npix, rows[i].base, 1'b1);
         setc(rows[i].ctrl & ~32'h0000_0001);
         `CHK(exp_q.size(), 0)
         $display("row %0d done", i);
      end
      // Embedded mode left idle between frames
      apb(1'b0, `CCC_STS_OFS, 32'h0000_0000);
      `CHK(rdat, 32'h0000_0003)
      setc(32'h0000_4001);
      word_ready <= 1'b0;
      shot(1, 4, 14'h0050, 1'b1);
      apb(1'b0, `CCC_STS_OFS, 32'h0000_0000);
      `CHK(rdat[`CCC_NEMP_BIT], 1'b1)
      word_ready <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, `CCC_STS_OFS, 32'h0000_0000);
      `CHK(rdat, 32'h0000_0000)
      $display("fifo flag test done");
      setc(32'h0000_0001);
      shot(1, 8, 14'h0060, 1'b0);
      apb(1'b0, `CCC_STS_OFS, 32'h0000_0000);
      `CHK(rdat, 32'h0000_0000)
      setc(32'h0000_4000);
      shot(1, 8, 14'h0070, 1'b0);
      `CHK(exp_q.size(), 0)
      $display("gating test done");
      setc(32'h0000_4003);
      shot(1, 8, 14'h0080, 1'b1);
      apb(1'b0, `CCC_CTRL_OFS, 32'h0000_0000);
      `CHK(rdat[`CCC_RUN_BIT], 1'b0)
      shot(1, 8, 14'h0090, 1'b0);
      `CHK(exp_q.size(), 0)
      $display("snapshot test done");
      for (int r = 1; r < 3; r++) begin
         setc(32'h0000_4001 | (r << 8));
         for (int f = 0; f < 5 - r; f++) shot(1, 8, 14'h00a0 + 14'(f * 16), f % (r + 1) == 0);
         setc(32'h0000_4000);
         `CHK(exp_q.size(), 0)
      end
      $display("rate test done");
      setc(32'h0000_4001);
      add_exp(16, 14'h00b0, 2'b00, 1'b0);
      fork
         cam.frame(2, 8, 1'b0, 14'h00b0);
         begin
            repeat (150) @(posedge pclk);
            apb(1'b1, `CCC_CTRL_OFS, 32'h0000_4000);
         end
      join
      repeat (40) @(posedge pclk);
      `CHK(exp_q.size(), 0)
      shot(1, 8, 14'h00c0, 1'b0);
      `CHK(exp_q.size(), 0)
      $display("stop test done");
      stop_test();
   end
endmodule
